// ---- hw/fprs_pkg.sv ----
/*
  Shared constants for the floating-point result and status block: register
  offsets, field positions, reset values, operation kinds, format codes and
  exponent ranges. Assumes nothing of its surroundings.
*/
package fprs_pkg;

  // ----------------------------------------------------------------
  // register map and field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] STATUS_OFS    = 32'h0000_0000;
  localparam logic [31:0] CONTROL_OFS   = 32'h0000_0004;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam int          CC_LSB        = 24;  // sign, zero, infinity, unordered
  localparam int          QUOT_LSB      = 16;  // quotient bits 22..16
  localparam int          QSIGN_BIT     = 23;  // sign of the whole quotient
  localparam int          EXC_LSB       = 8;   // fault flags byte
  localparam int          EXC_OVF_IDX   = 4;
  localparam int          EXC_UNF_IDX   = 3;
  localparam int          EXC_INX_IDX   = 1;
  localparam int          WSEL_LSB      = 6;   // rounding width select
  localparam int          MODE_LSB      = 4;   // rounding mode
  localparam int          CC_SIGN       = 3;
  localparam int          CC_ZERO       = 2;
  localparam int          CC_INF        = 1;
  localparam int          CC_UNORD      = 0;

  // ----------------------------------------------------------------
  // format and rounding codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_EXT = 2'h0;
  localparam logic [1:0] FMT_SGL = 2'h1;
  localparam logic [1:0] FMT_DBL = 2'h2;
  localparam logic [1:0] RND_NEAR = 2'h0;
  localparam logic [1:0] RND_ZERO = 2'h1;
  localparam logic [1:0] RND_MINUS = 2'h2;
  localparam logic [1:0] RND_PLUS = 2'h3;

  // ----------------------------------------------------------------
  // widths, biases and exponent ranges
  // ----------------------------------------------------------------
  localparam int             EXT_WIDTH = 64;
  localparam int             DBL_WIDTH = 53;
  localparam int             SGL_WIDTH = 24;
  localparam logic [15:0]    EXT_BIAS  = 16'h3fff;
  localparam logic [15:0]    DBL_BIAS  = 16'h03ff;
  localparam logic [15:0]    SGL_BIAS  = 16'h007f;
  localparam logic [14:0]    EXT_ALL1  = 15'h7fff;
  localparam logic [14:0]    DBL_ALL1  = 15'h07ff;
  localparam logic [14:0]    SGL_ALL1  = 15'h00ff;
  localparam logic [14:0]    DBL_REBIAS = 15'h3c00;  // ext bias minus dbl bias
  localparam logic [14:0]    SGL_REBIAS = 15'h3f80;  // ext bias minus sgl bias
  localparam logic [14:0]    DBL_DEN_EXP = 15'h3c01; // ext exponent of dbl denormal
  localparam logic [14:0]    SGL_DEN_EXP = 15'h3f81; // ext exponent of sgl denormal

  // ----------------------------------------------------------------
  // operation kinds issued by the integer unit
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ARITH,
    OP_COMPARE,
    OP_LOAD,
    OP_STORE,
    OP_MULTI_MOVE,
    OP_CTRL_MOVE,
    OP_MODULO,
    OP_REMAINDER
  } fprs_op_e;

endpackage

// ---- hw/fprs_result_status.sv ----
/*
  Floating-point result handling and status logic: operand conversion and
  normalisation, rounding of the intermediate result, and the status and
  control registers on an AHB-Lite slave port.
  Assumes one clock, an integer unit that presents one operation per
  valid cycle on the same clock, and a single-master AHB-Lite bus.
*/
`timescale 1ns/1ps

module fprs_result_status
  import fprs_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o,
  input  wire logic              op_valid_i,
  input  wire fprs_pkg::fprs_op_e op_kind_i,
  input  wire logic              dest_mem_i,
  input  wire logic [1:0]        dest_fmt_i,
  input  wire logic [1:0]        src_fmt_i,
  input  wire logic [79:0]       src_bits_i,
  input  wire logic              res_sign_i,
  input  wire logic [15:0]       res_exp_i,
  input  wire logic [66:0]       res_mant_i,
  input  wire logic              res_inf_i,
  input  wire logic              res_unord_i,
  input  wire logic              cmp_unord_i,
  input  wire logic [6:0]        quot_i,
  input  wire logic              quot_sign_i,
  input  wire logic [7:0]        exc_raise_i,
  output logic                   opnd_valid_o,
  output logic                   opnd_sign_o,
  output logic [15:0]            opnd_exp_o,
  output logic [63:0]            opnd_mant_o,
  output logic                   res_valid_o,
  output logic                   out_sign_o,
  output logic [14:0]            out_exp_o,
  output logic [63:0]            out_mant_o,
  output logic                   ovf_trap_o,
  output logic                   cond_eq_o,
  output logic                   cond_gt_o,
  output logic                   cond_lt_o,
  output logic                   cond_un_o
);
  import fprs_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // async assert, release through two flops
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // leading zeros of a 64-bit mantissa, 64 when all zero
  function automatic logic [6:0] lzc64(input logic [63:0] m);
    logic [6:0] n;
    logic       hit;
    n   = 7'd64;
    hit = 1'b0;
    for (int k = 63; k >= 0; k--)
    begin
      if (!hit && m[k])
      begin
        n   = 7'(63 - k);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // memory format to extended: {sign, exp15, mant64}
  function automatic logic [79:0] to_ext(input logic [1:0] fmt, input logic [79:0] b);
    logic [79:0] r;
    r = b;
    if (fmt == FMT_DBL)
    begin
      if (b[62:52] == 11'h7ff)
        r = {b[63], EXT_ALL1, 1'b1, b[51:0], 11'h000};
      else if (b[62:52] == 11'h000)
        r = {b[63], (b[51:0] == 52'h0) ? 15'h0 : DBL_DEN_EXP, 1'b0, b[51:0], 11'h000};
      else
        r = {b[63], {4'h0, b[62:52]} + DBL_REBIAS, 1'b1, b[51:0], 11'h000};
    end
    else if (fmt == FMT_SGL)
    begin
      if (b[30:23] == 8'hff)
        r = {b[31], EXT_ALL1, 1'b1, b[22:0], 40'h0};
      else if (b[30:23] == 8'h00)
        r = {b[31], (b[22:0] == 23'h0) ? 15'h0 : SGL_DEN_EXP, 1'b0, b[22:0], 40'h0};
      else
        r = {b[31], {7'h00, b[30:23]} + SGL_REBIAS, 1'b1, b[22:0], 40'h0};
    end
    return r;
  endfunction

  // round 67-bit mantissa to w bits: {carry, inexact, mant64}
  function automatic logic [65:0] round67(input logic [66:0] m, input int w,
                                          input logic [1:0] mode, input logic s);
    logic [66:0] lsb;
    logic [66:0] half;
    logic [66:0] frac;
    logic [67:0] sum;
    logic        up;
    logic        inx;
    logic        carry;
    lsb  = {66'h0, 1'b1} << (67 - w);
    half = lsb >> 1;
    frac = m & (lsb - 67'h1);
    inx  = (frac != 67'h0);
    unique case (mode)
      RND_NEAR:  up = (frac > half) || ((frac == half) && ((m & lsb) != 67'h0));
      RND_ZERO:  up = 1'b0;
      RND_MINUS: up = s & inx;
      RND_PLUS:  up = ~s & inx;
    endcase
    sum = {1'b0, m & ~(lsb - 67'h1)} + (up ? {1'b0, lsb} : 68'h0);
    carry = sum[67];
    if (carry)
      sum = sum >> 1;
    return {carry, inx, sum[66:3]};
  endfunction

  // ----------------------------------------------------------------
  // operand conversion and normalisation
  // ----------------------------------------------------------------
  logic [79:0] src_ext;
  logic [6:0]  src_lz;
  logic [15:0] src_base;
  logic        norm_needed;

  assign src_ext  = to_ext(src_fmt_i, src_bits_i);
  assign src_lz   = lzc64(src_ext[63:0]);
  // a denormal's effective exponent is one, not zero
  assign src_base = (src_ext[78:64] == 15'h0) ? 16'h0001 : {1'b0, src_ext[78:64]};
  assign norm_needed = (op_kind_i != OP_LOAD);

  // operand handed to the arithmetic unit, or into a register as loaded
  always_ff @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      opnd_valid_o <= 1'b0;
      opnd_sign_o  <= 1'b0;
      opnd_exp_o   <= 16'h0;
      opnd_mant_o  <= 64'h0;
    end
    else
    begin
      opnd_valid_o <= op_valid_i && (op_kind_i inside {OP_ARITH, OP_COMPARE, OP_LOAD,
                                                       OP_MODULO, OP_REMAINDER});
      opnd_sign_o  <= src_ext[79];
      if (!norm_needed || src_ext[78:64] == EXT_ALL1)
      begin
        opnd_exp_o  <= {1'b0, src_ext[78:64]};
        opnd_mant_o <= src_ext[63:0];
      end
      else if (src_ext[63:0] == 64'h0)
      begin
        opnd_exp_o  <= 16'h0;
        opnd_mant_o <= 64'h0;
      end
      else
      begin
        opnd_exp_o  <= src_base - {9'h0, src_lz};
        opnd_mant_o <= src_ext[63:0] << src_lz;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  logic [1:0] wsel_reg;
  logic [1:0] mode_reg;

  // ----------------------------------------------------------------
  // rounding of the intermediate result
  // ----------------------------------------------------------------
  logic [1:0]  eff_fmt;
  int          eff_w;
  logic [15:0] emax;
  logic [15:0] emin;
  logic [15:0] out_bias;
  logic [14:0] out_all1;
  logic [65:0] rnd;
  logic [15:0] exp_r;
  logic        unf;
  logic        ovf;
  logic        special;
  logic [15:0] exp_biased;

  // memory destinations ignore the width select
  assign eff_fmt = dest_mem_i ? dest_fmt_i : wsel_reg;
  assign special = res_inf_i | res_unord_i;

  // width and exponent range of the effective precision
  always_comb
  begin
    unique case (eff_fmt)
      FMT_SGL:
      begin
        eff_w = SGL_WIDTH;
        emax  = SGL_BIAS;
      end
      FMT_DBL:
      begin
        eff_w = DBL_WIDTH;
        emax  = DBL_BIAS;
      end
      default:
      begin
        eff_w = EXT_WIDTH;
        emax  = EXT_BIAS;
      end
    endcase
    emin = 16'h0001 - emax;
    // register destination keeps extended bias even at narrow width
    out_bias = (dest_mem_i && eff_fmt == FMT_DBL) ? DBL_BIAS :
               (dest_mem_i && eff_fmt == FMT_SGL) ? SGL_BIAS : EXT_BIAS;
    out_all1 = (dest_mem_i && eff_fmt == FMT_DBL) ? DBL_ALL1 :
               (dest_mem_i && eff_fmt == FMT_SGL) ? SGL_ALL1 : EXT_ALL1;
  end

  // signed compare on the 16-bit two's-complement exponent
  assign unf = !special && res_mant_i != 67'h0
               && ($signed(res_exp_i) < $signed(emin));
  // an underflowed result is truncated, not rounded
  assign rnd = unf ? round67(res_mant_i, eff_w, RND_ZERO, res_sign_i)
                   : round67(res_mant_i, eff_w, mode_reg, res_sign_i);
  assign exp_r = res_exp_i + {15'h0, rnd[65]};
  assign ovf = !special && res_mant_i != 67'h0
               && ($signed(exp_r) > $signed(emax));
  // wraps on purpose when out of range so the handler can rescale
  assign exp_biased = exp_r + out_bias;

  // ----------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------
  logic writes_dest;

  assign writes_dest = op_valid_i && (op_kind_i inside {OP_ARITH, OP_LOAD, OP_STORE,
                                                        OP_MODULO, OP_REMAINDER});

  // rounded result with tail bits forced to zero, except loads, infinities and NaNs, which pass unrounded
  always_ff @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      res_valid_o <= 1'b0;
      out_sign_o  <= 1'b0;
      out_exp_o   <= 15'h0;
      out_mant_o  <= 64'h0;
      ovf_trap_o  <= 1'b0;
    end
    else
    begin
      res_valid_o <= writes_dest;
      ovf_trap_o  <= op_valid_i && writes_dest && ovf;
      if (op_kind_i == OP_LOAD)
      begin
        out_sign_o <= src_ext[79];
        out_exp_o  <= src_ext[78:64];
        out_mant_o <= src_ext[63:0];
      end
      else
      begin
        out_sign_o <= res_sign_i;
        out_exp_o  <= special ? out_all1 :
                      (res_mant_i == 67'h0) ? 15'h0 : exp_biased[14:0];
        out_mant_o <= special ? res_mant_i[66:3] : rnd[63:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // result classification
  // ----------------------------------------------------------------
  logic [3:0] cc_new;
  logic       ld_inf;
  logic       ld_unord;

  assign ld_inf   = (src_ext[78:64] == EXT_ALL1) && (src_ext[62:0] == 63'h0);
  assign ld_unord = (src_ext[78:64] == EXT_ALL1) && (src_ext[62:0] != 63'h0);

  // one of eight legal codes: sign plus at most one class bit
  always_comb
  begin
    if (op_kind_i == OP_LOAD)
    begin
      cc_new = {src_ext[79], !ld_inf && !ld_unord && src_ext[63:0] == 64'h0,
                ld_inf, ld_unord};
    end
    else
    begin
      cc_new = {res_sign_i, !special && res_mant_i == 67'h0,
                res_inf_i && !res_unord_i, res_unord_i};
      if (op_kind_i == OP_COMPARE && cmp_unord_i)
        cc_new = {res_sign_i, 3'b001};
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        dph_reg;
  logic        dwr_reg;
  logic [31:0] daddr_reg;
  logic        bus_wr;
  logic        wr_status;
  logic        wr_control;

  // capture the address phase; every transfer completes with no wait
  always_ff @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      dph_reg   <= 1'b0;
      dwr_reg   <= 1'b0;
      daddr_reg <= 32'h0;
    end
    else if (hready_i)
    begin
      dph_reg   <= hsel_i && htrans_i[1];
      dwr_reg   <= hwrite_i;
      daddr_reg <= haddr_i;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign bus_wr      = dph_reg && dwr_reg;
  assign wr_status   = bus_wr && daddr_reg == STATUS_OFS;
  assign wr_control  = bus_wr && daddr_reg == CONTROL_OFS;

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  logic [3:0] cc_reg;
  logic [7:0] quot_reg;
  logic [7:0] exc_reg;
  logic [7:0] exc_new;
  logic       touches_cc;
  logic       clears_exc;

  // rounding controls steer the rounding path above
  always_ff @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wsel_reg <= CONTROL_RESET[WSEL_LSB +: 2];
      mode_reg <= CONTROL_RESET[MODE_LSB +: 2];
    end
    else if (wr_control)
    begin
      wsel_reg <= hwdata_i[WSEL_LSB +: 2];
      mode_reg <= hwdata_i[MODE_LSB +: 2];
    end
  end

  assign touches_cc = op_valid_i && !(op_kind_i inside {OP_STORE, OP_MULTI_MOVE,
                                                        OP_CTRL_MOVE});
  assign clears_exc = op_valid_i && !(op_kind_i inside {OP_MULTI_MOVE,
                                                        OP_CTRL_MOVE});

  // this operation's faults on a freshly cleared byte
  always_comb
  begin
    exc_new = exc_raise_i;
    if (writes_dest && op_kind_i != OP_LOAD && !special)
    begin
      exc_new[EXC_INX_IDX] = exc_raise_i[EXC_INX_IDX] | rnd[64] | ovf;
      exc_new[EXC_OVF_IDX] = exc_raise_i[EXC_OVF_IDX] | ovf;
      exc_new[EXC_UNF_IDX] = exc_raise_i[EXC_UNF_IDX] | unf;
    end
  end

  // hardware update wins over a same-cycle software write
  always_ff @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      cc_reg <= STATUS_RESET[CC_LSB +: 4];
    else if (touches_cc)
      cc_reg <= cc_new;
    else if (wr_status)
      cc_reg <= hwdata_i[CC_LSB +: 4];
  end

  // quotient stays until the next modulo or remainder, or a software write, replaces it
  always_ff @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      quot_reg <= STATUS_RESET[QUOT_LSB +: 8];
    else if (op_valid_i && op_kind_i inside {OP_MODULO, OP_REMAINDER})
      quot_reg <= {quot_sign_i, quot_i};
    else if (wr_status)
      quot_reg <= hwdata_i[QUOT_LSB +: 8];
  end

  // fault flags byte
  always_ff @(posedge core_clk_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      exc_reg <= STATUS_RESET[EXC_LSB +: 8];
    else if (clears_exc)
      exc_reg <= exc_new;
    else if (wr_status)
      exc_reg <= hwdata_i[EXC_LSB +: 8];
  end

  // read mux over flops; unmapped reads return zero
  always_comb
  begin
    hrdata_o = 32'h0;
    if (dph_reg && !dwr_reg && daddr_reg == STATUS_OFS)
    begin
      hrdata_o[CC_LSB +: 4]   = cc_reg;
      hrdata_o[QUOT_LSB +: 8] = quot_reg;
      hrdata_o[EXC_LSB +: 8]  = exc_reg;
    end
    else if (dph_reg && !dwr_reg && daddr_reg == CONTROL_OFS)
    begin
      hrdata_o[WSEL_LSB +: 2] = wsel_reg;
      hrdata_o[MODE_LSB +: 2] = mode_reg;
    end
  end

  // ----------------------------------------------------------------
  // IEEE relations derived from the raw flags
  // ----------------------------------------------------------------
  assign cond_un_o = cc_reg[CC_UNORD];
  assign cond_eq_o = cc_reg[CC_ZERO] & ~cc_reg[CC_UNORD];
  assign cond_gt_o = ~(cc_reg[CC_UNORD] | cc_reg[CC_ZERO] | cc_reg[CC_SIGN]);
  assign cond_lt_o = cc_reg[CC_SIGN] & ~(cc_reg[CC_UNORD] | cc_reg[CC_ZERO]);

endmodule

// ---- bench/fprs_monitor.sv ----
/*
  Port checker for the fp result and status block.
  Assumes the bind below and one clock domain.
*/
`timescale 1ns/1ps
// ------------------------------------------------
// checker
// ------------------------------------------------
module fprs_monitor
  import fprs_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              arst_n_i,
  input wire logic              op_valid_i,
  input wire fprs_pkg::fprs_op_e op_kind_i,
  input wire logic              res_sign_i,
  input wire logic [66:0]       res_mant_i,
  input wire logic              res_inf_i,
  input wire logic              res_unord_i,
  input wire logic              cmp_unord_i,
  input wire logic              res_valid_o,
  input wire logic              ovf_trap_o,
  input wire logic              cond_eq_o,
  input wire logic              cond_gt_o,
  input wire logic              cond_lt_o,
  input wire logic              cond_un_o
);
  // results land one edge after the op is taken
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_arith;
    op_valid_i && op_kind_i == OP_ARITH;
  endsequence
  sequence s_fin;
    s_arith ##0 (!res_inf_i && !res_unord_i);
  endsequence
  property p_res; s_arith |=> res_valid_o; endproperty
  a_res: assert property (p_res) else $error("no result pulse");
  property p_keep;
    op_valid_i && op_kind_i inside {OP_STORE, OP_MULTI_MOVE, OP_CTRL_MOVE}
      |=> $stable({cond_eq_o, cond_gt_o, cond_lt_o, cond_un_o});
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_cmpun; op_valid_i && op_kind_i == OP_COMPARE && cmp_unord_i |=> cond_un_o; endproperty
  a_cmpun: assert property (p_cmpun) else $error("unordered compare lost");
  property p_nan; s_arith ##0 res_unord_i |=> cond_un_o && !cond_eq_o; endproperty
  a_nan: assert property (p_nan) else $error("nan result lost");
  property p_inf;
    s_arith ##0 (res_inf_i && !res_unord_i) |=> !cond_un_o && cond_lt_o == $past(res_sign_i);
  endproperty
  a_inf: assert property (p_inf) else $error("infinity flags wrong");
  property p_zero; s_fin ##0 res_mant_i == 0 |=> cond_eq_o && !cond_gt_o && !cond_lt_o; endproperty
  a_zero: assert property (p_zero) else $error("zero relation wrong");
  property p_ovf; ovf_trap_o |-> res_valid_o; endproperty
  a_ovf: assert property (p_ovf) else $error("trap without result");
  property p_noop; !op_valid_i |=> !res_valid_o && !ovf_trap_o; endproperty
  a_noop: assert property (p_noop) else $error("result with no op");
endmodule

bind fprs_result_status fprs_monitor u_fprs_monitor (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i),
  .op_kind_i(op_kind_i), .res_sign_i(res_sign_i), .res_mant_i(res_mant_i),
  .res_inf_i(res_inf_i), .res_unord_i(res_unord_i), .cmp_unord_i(cmp_unord_i),
  .res_valid_o(res_valid_o), .ovf_trap_o(ovf_trap_o), .cond_eq_o(cond_eq_o),
  .cond_gt_o(cond_gt_o), .cond_lt_o(cond_lt_o), .cond_un_o(cond_un_o));

// ---- bench/fprs_iu_model.sv ----
/*
  Integer unit model: issues one fp operation per call of issue.
  Assumes the caller enters just after a rising edge.
*/
`timescale 1ns/1ps
module fprs_iu_model
  import fprs_pkg::*;
(
  input  wire logic   core_clk_i,
  output logic        op_valid_o,
  output fprs_op_e    op_kind_o,
  output logic        res_sign_o,
  output logic [15:0] res_exp_o,
  output logic [66:0] res_mant_o,
  output logic        res_inf_o,
  output logic        res_unord_o,
  output logic        cmp_unord_o,
  output logic [6:0]  quot_o,
  output logic        quot_sign_o,
  output logic [79:0] src_bits_o
);
  // idle at time zero
  initial
  begin
    {op_valid_o, res_sign_o, res_exp_o, res_mant_o, res_inf_o, res_unord_o} = '0;
    {cmp_unord_o, quot_o, quot_sign_o, src_bits_o} = '0;
    op_kind_o = OP_ARITH;
  end
  // f is {sign, inf, unord, cmp unord}; stale mantissa inverted after the pulse
  task automatic issue(input fprs_op_e k, input logic [3:0] f, input logic [15:0] e,
                       input logic [66:0] m, input logic [7:0] q);
    op_valid_o <= 1'b1;
    op_kind_o <= k;
    {res_sign_o, res_inf_o, res_unord_o, cmp_unord_o} <= f;
    res_exp_o <= e;
    res_mant_o <= m;
    {quot_sign_o, quot_o} <= q;
    src_bits_o <= {f[3], 15'h3fff, m[66:3]};
    @(posedge core_clk_i);
    op_valid_o <= 1'b0;
    res_mant_o <= ~m;
  endtask
endmodule

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the fp result and status block.
  Assumes the AHB slave answers without wait states.
*/
`timescale 1ns/1ps
module tb_top;
  import fprs_pkg::*;
  logic        core_clk_i, arst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]  htrans_i;
  logic        op_valid_i, res_sign_i, res_inf_i, res_unord_i, cmp_unord_i, quot_sign_i;
  fprs_op_e    op_kind_i;
  logic [15:0] res_exp_i, oe;
  logic [14:0] ox;
  logic [66:0] res_mant_i;
  logic [6:0]  quot_i;
  logic [79:0] src_bits_i;
  logic        res_valid_o, ovf_trap_o, ce, cg, cl, cu, dm;
  logic [63:0] out_mant_o, om;
  logic [12:0] r;
  int          failures, n_tests;
  // rows: kind, {sign,inf,unord,cmpu}, zero mant, result pulse, expected flags
  logic [12:0] rows [10] = '{13'h0010, 13'h031a, 13'h0441, 13'h0218, 13'h0c18,
                             13'h1008, 13'h1408, 13'h0034, 13'h0091, 13'h0810};
  fprs_result_status u_fprs_result_status (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .op_valid_i(op_valid_i), .op_kind_i(op_kind_i), .dest_mem_i(dm),
    .dest_fmt_i({dm, 1'b0}), .src_fmt_i(FMT_EXT), .src_bits_i(src_bits_i),
    .res_sign_i(res_sign_i), .res_exp_i(res_exp_i), .res_mant_i(res_mant_i),
    .res_inf_i(res_inf_i), .res_unord_i(res_unord_i), .cmp_unord_i(cmp_unord_i),
    .quot_i(quot_i), .quot_sign_i(quot_sign_i), .exc_raise_i(8'h00), .opnd_valid_o(),
    .opnd_sign_o(), .opnd_exp_o(oe), .opnd_mant_o(om), .res_valid_o(res_valid_o),
    .out_sign_o(), .out_exp_o(ox), .out_mant_o(out_mant_o), .ovf_trap_o(ovf_trap_o),
    .cond_eq_o(ce), .cond_gt_o(cg), .cond_lt_o(cl), .cond_un_o(cu));
  fprs_iu_model u_fprs_iu_model (
    .core_clk_i(core_clk_i), .op_valid_o(op_valid_i), .op_kind_o(op_kind_i),
    .res_sign_o(res_sign_i), .res_exp_o(res_exp_i), .res_mant_o(res_mant_i),
    .res_inf_o(res_inf_i), .res_unord_o(res_unord_i), .cmp_unord_o(cmp_unord_i),
    .quot_o(quot_i), .quot_sign_o(quot_sign_i), .src_bits_o(src_bits_i));
  // 100 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one single transfer; read data taken at the edge ending the data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1 && ++n < 99);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1 && ++n < 99);
    rd = hrdata_o;
    if (n >= 99)
    begin
      failures++;
      test_done;
    end
  endtask
  // main sequence
  initial
  begin
    {arst_n_i, dm, hwrite_i, haddr_i, hwdata_i, htrans_i, failures, n_tests} = '0;
    hsel_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    ahb(0, STATUS_OFS, 0);
    chk("status reset", STATUS_RESET, rd);
    ahb(0, CONTROL_OFS, 0);
    chk("control reset", CONTROL_RESET, rd);
    for (int i = 0; i < 10; i++)
    begin
      r = rows[i];
      u_fprs_iu_model.issue(fprs_op_e'(r[12:10]), r[9:6], 0, r[5] ? '0 : {1'b1, 66'h0}, 0);
      #1;
      chk("res_valid", r[4], res_valid_o);
      chk("relations", {r[2], !(r[3] | r[2] | r[0]), r[3] & !r[2] & !r[0], r[0]},
          {ce, cg, cl, cu});
      ahb(0, STATUS_OFS, 0);
      chk("cc", r[3:0], rd[27:24]);
    end
    ahb(1, STATUS_OFS, 32'hffff_ffff);
    ahb(0, STATUS_OFS, 0);
    chk("status write", 32'h0fff_ff00, rd);
    ahb(1, 32'h8, 32'h1234_5678);
    ahb(0, 32'h8, 0);
    chk("unmapped", 0, rd);
    u_fprs_iu_model.issue(OP_MULTI_MOVE, 0, 0, 0, 0);
    ahb(0, STATUS_OFS, 0);
    chk("fault kept", 8'hff, rd[15:8]);
    u_fprs_iu_model.issue(OP_MODULO, 0, 0, {1'b1, 66'h0}, 8'h85);
    ahb(0, STATUS_OFS, 0);
    chk("quotient", 8'h85, rd[23:16]);
    chk("fault cleared", 0, rd[15:8]);
    u_fprs_iu_model.issue(OP_ARITH, 0, 0, {1'b1, 66'h0}, 0);
    ahb(0, STATUS_OFS, 0);
    chk("quotient held", 8'h85, rd[23:16]);
    // single width: tail below 24 bits zeroed, lost bits flagged
    ahb(1, CONTROL_OFS, 32'h40);
    u_fprs_iu_model.issue(OP_ARITH, 0, 0, {1'b1, 66'h0} | 67'h10_0000, 0);
    #1;
    chk("tail", 64'h8000_0000_0000_0000, out_mant_o);
    ahb(0, STATUS_OFS, 0);
    chk("inexact", 1, rd[9]);
    ahb(1, CONTROL_OFS, 0);
    u_fprs_iu_model.issue(OP_ARITH, 0, 16'h4000, {1'b1, 66'h0}, 0);
    #1;
    chk("trap", 1, ovf_trap_o);
    ahb(0, STATUS_OFS, 0);
    chk("overflow", 1, rd[12]);
    // unnormal: normalised unless loaded
    u_fprs_iu_model.issue(OP_ARITH, 0, 0, 67'h1 << 64, 0);
    #1;
    chk("norm exp", 16'h3ffd, oe);
    chk("norm mant", 64'h8000_0000_0000_0000, om);
    u_fprs_iu_model.issue(OP_LOAD, 0, 0, 67'h1 << 64, 0);
    #1;
    chk("load mant", 64'h2000_0000_0000_0000, om);
    u_fprs_iu_model.issue(OP_ARITH, 0, 0, 0, 0);
    #1;
    chk("zero exp", 0, oe);
    // memory destination: double width and bias
    dm <= 1'b1;
    u_fprs_iu_model.issue(OP_ARITH, 0, 0, {1'b1, 66'h8}, 0);
    #1;
    chk("mem exp", 15'h03ff, ox);
    chk("mem mant", 64'h8000_0000_0000_0000, out_mant_o);
    // mid-run reset
    arst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    ahb(0, STATUS_OFS, 0);
    chk("status after reset", STATUS_RESET, rd);
    test_done;
  end
endmodule
